// File: rtl/drp_bank.v
// apb register bank for the first reference input profile of the first digital loop
//
// Overview of operation
// - bits 2:1 of first register set priority, 00 highest to 11 lowest, reset 00.
// - bit 0 of first register enables the reference as a lock source; reset off.
// - seventeen-bit bandwidth scale in 0.1 Hz steps over three registers, reset zero.
// - bit 1 of fourth register picks high phase margin filter; zero gives normal.
// - eighteen-bit integer divisor stored minus one; all zeros divides by one.
// - twenty-four-bit fractional numerator, low byte first, resets to zero.
// - twenty-four-bit modulus, low byte first; zero bypasses the fractional divider.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "drp_defines.vh"

module drp_bank #(
	parameter ADDR_W = 16,
	parameter BW_W = 17,
	parameter INT_W = 18,
	parameter FRAC_W = 24
) (
	input wire clock,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg ref_lock_enable,
	output reg [1:0] ref_priority,
	output reg [BW_W-1:0] loop_bw_scale,
	output reg high_margin_filter,
	output reg [INT_W-1:0] integer_feedback_divisor,
	output reg [FRAC_W-1:0] fractional_numerator,
	output reg [FRAC_W-1:0] fractional_modulus,
	output wire [INT_W:0] ratio_integer,
	output wire [FRAC_W-1:0] ratio_numerator,
	output wire [FRAC_W-1:0] ratio_modulus,
	output wire frac_bypass,
	output reg bw_zero_warning
);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// word aligned hit on a register index
	function hit;
		input [ADDR_W-1:0] addr;
		input [13:0] idx;
		begin
			hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]);
		end
	endfunction

	// byte lane read back, upper bits zero
	function [31:0] widen;
		input [7:0] val;
		begin
			widen = {24'h00_0000, val};
		end
	endfunction

	// zero scale test shared by the status bit and the warning
	function is_zero_scale;
		input [BW_W-1:0] val;
		begin
			is_zero_scale = (val == `DRP_RST_BW);
		end
	endfunction

	// ----------------------------------------------------------------
	// bank storage
	// ----------------------------------------------------------------
	reg [7:0] prio_en;
	reg [7:0] bw_low;
	reg [7:0] bw_mid;
	reg [7:0] filt_bw_top;
	reg [7:0] int_low;
	reg [7:0] int_mid;
	reg [7:0] int_top;
	reg [7:0] num_low;
	reg [7:0] num_mid;
	reg [7:0] num_high;
	reg [7:0] mod_low;
	reg [7:0] mod_mid;
	reg [7:0] mod_high;
	reg [7:0] status;

	wire access;
	wire wr_now;
	wire rd_now;
	wire mapped;
	wire writable;
	wire num_ge_mod;
	reg [31:0] next_prdata;

	// access phase that has not yet been answered
	assign access = psel && penable && !pready;
	// the write lands on the edge that also sees pready high
	assign wr_now = psel && penable && pready && pwrite && writable;
	assign rd_now = access && !pwrite;

	assign writable = hit(paddr, `DRP_IDX_PRIO_EN) || hit(paddr, `DRP_IDX_BW_LOW) ||
		hit(paddr, `DRP_IDX_BW_MID) || hit(paddr, `DRP_IDX_FILT_BW_TOP) ||
		hit(paddr, `DRP_IDX_INT_LOW) || hit(paddr, `DRP_IDX_INT_MID) ||
		hit(paddr, `DRP_IDX_INT_TOP) || hit(paddr, `DRP_IDX_NUM_LOW) ||
		hit(paddr, `DRP_IDX_NUM_MID) || hit(paddr, `DRP_IDX_NUM_HIGH) ||
		hit(paddr, `DRP_IDX_MOD_LOW) || hit(paddr, `DRP_IDX_MOD_MID) ||
		hit(paddr, `DRP_IDX_MOD_HIGH);
	assign mapped = writable || hit(paddr, `DRP_IDX_STATUS);

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------
	// one wait state: pready rises the cycle after the access phase opens
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= access;
			// unmapped, misaligned, or write to the read-only status word
			pslverr <= access && (!mapped || (pwrite && !writable));
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// reserved bits are not stored so they read as zero
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prio_en <= `DRP_RST_BYTE;
			bw_low <= `DRP_RST_BYTE;
			bw_mid <= `DRP_RST_BYTE;
			filt_bw_top <= `DRP_RST_BYTE;
			int_low <= `DRP_RST_BYTE;
			int_mid <= `DRP_RST_BYTE;
			int_top <= `DRP_RST_BYTE;
			num_low <= `DRP_RST_BYTE;
			num_mid <= `DRP_RST_BYTE;
			num_high <= `DRP_RST_BYTE;
			mod_low <= `DRP_RST_BYTE;
			mod_mid <= `DRP_RST_BYTE;
			mod_high <= `DRP_RST_BYTE;
		end else if (wr_now) begin
			if (hit(paddr, `DRP_IDX_PRIO_EN)) begin
				prio_en <= {5'h00, pwdata[2:0]};
			end
			if (hit(paddr, `DRP_IDX_BW_LOW)) begin
				bw_low <= pwdata[7:0];
			end
			if (hit(paddr, `DRP_IDX_BW_MID)) begin
				bw_mid <= pwdata[7:0];
			end
			// filter select with bandwidth top bit
			if (hit(paddr, `DRP_IDX_FILT_BW_TOP)) begin
				filt_bw_top <= {6'h00, pwdata[1:0]};
			end
			if (hit(paddr, `DRP_IDX_INT_LOW)) begin
				int_low <= pwdata[7:0];
			end
			if (hit(paddr, `DRP_IDX_INT_MID)) begin
				int_mid <= pwdata[7:0];
			end
			if (hit(paddr, `DRP_IDX_INT_TOP)) begin
				int_top <= {6'h00, pwdata[1:0]};
			end
			if (hit(paddr, `DRP_IDX_NUM_LOW)) begin
				num_low <= pwdata[7:0];
			end
			if (hit(paddr, `DRP_IDX_NUM_MID)) begin
				num_mid <= pwdata[7:0];
			end
			if (hit(paddr, `DRP_IDX_NUM_HIGH)) begin
				num_high <= pwdata[7:0];
			end
			if (hit(paddr, `DRP_IDX_MOD_LOW)) begin
				mod_low <= pwdata[7:0];
			end
			if (hit(paddr, `DRP_IDX_MOD_MID)) begin
				mod_mid <= pwdata[7:0];
			end
			if (hit(paddr, `DRP_IDX_MOD_HIGH)) begin
				mod_high <= pwdata[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// loop-facing fields
	// ----------------------------------------------------------------
	// fields follow the bank one cycle later; a multi-byte field is seen
	// byte by byte, so software should disable the reference while editing
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ref_lock_enable <= 1'b0;
			ref_priority <= `DRP_RST_PRIO;
			loop_bw_scale <= `DRP_RST_BW;
			high_margin_filter <= 1'b0;
			integer_feedback_divisor <= `DRP_RST_INT;
			fractional_numerator <= `DRP_RST_FRAC;
			fractional_modulus <= `DRP_RST_FRAC;
		end else begin
			ref_lock_enable <= prio_en[`DRP_ENABLE_BIT];
			ref_priority <= prio_en[`DRP_PRIO_MSB:`DRP_PRIO_LSB];
			loop_bw_scale <= {filt_bw_top[`DRP_BW_TOP_BIT], bw_mid, bw_low};
			high_margin_filter <= filt_bw_top[`DRP_FILTER_BIT];
			integer_feedback_divisor <= {int_top[`DRP_INT_TOP_MSB:0], int_mid, int_low};
			fractional_numerator <= {num_high, num_mid, num_low};
			fractional_modulus <= {mod_high, mod_mid, mod_low};
		end
	end

	// ----------------------------------------------------------------
	// effective ratio
	// ----------------------------------------------------------------
	// ratio from assembled fields
	drp_ratio #(
		.INT_W(INT_W),
		.FRAC_W(FRAC_W)
	) u_ratio (
		.clock(clock),
		.rst_n(rst_n),
		.int_field(integer_feedback_divisor),
		.num_field(fractional_numerator),
		.mod_field(fractional_modulus),
		.ratio_integer(ratio_integer),
		.ratio_numerator(ratio_numerator),
		.ratio_modulus(ratio_modulus),
		.frac_bypass(frac_bypass),
		.num_ge_mod(num_ge_mod)
	);

	// ----------------------------------------------------------------
	// status word
	// ----------------------------------------------------------------
	// software misuse is reported, not corrected: the loop keeps what was written
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status <= `DRP_RST_BYTE;
			bw_zero_warning <= 1'b0;
		end else begin
			status[`DRP_ST_FRAC_BYPASS] <= frac_bypass;
			status[`DRP_ST_BW_ZERO] <= is_zero_scale(loop_bw_scale);
			status[`DRP_ST_FILTER_ADVICE] <= (loop_bw_scale > `DRP_HIGH_PM_ADVICE) &&
				!high_margin_filter;
			status[`DRP_ST_NUM_GE_MOD] <= num_ge_mod;
			status[`DRP_ST_ELIGIBLE] <= ref_lock_enable;
			// spare bits read as zero
			status[7:5] <= 3'h0;
			bw_zero_warning <= ref_lock_enable && is_zero_scale(loop_bw_scale);
		end
	end

	// ----------------------------------------------------------------
	// read back
	// ----------------------------------------------------------------
	// unmapped reads return zero
	always @* begin
		next_prdata = 32'h0000_0000;
		if (hit(paddr, `DRP_IDX_PRIO_EN)) begin
			next_prdata = widen(prio_en);
		end
		if (hit(paddr, `DRP_IDX_BW_LOW)) begin
			next_prdata = widen(bw_low);
		end
		if (hit(paddr, `DRP_IDX_BW_MID)) begin
			next_prdata = widen(bw_mid);
		end
		if (hit(paddr, `DRP_IDX_FILT_BW_TOP)) begin
			next_prdata = widen(filt_bw_top);
		end
		if (hit(paddr, `DRP_IDX_INT_LOW)) begin
			next_prdata = widen(int_low);
		end
		if (hit(paddr, `DRP_IDX_INT_MID)) begin
			next_prdata = widen(int_mid);
		end
		if (hit(paddr, `DRP_IDX_INT_TOP)) begin
			next_prdata = widen(int_top);
		end
		if (hit(paddr, `DRP_IDX_NUM_LOW)) begin
			next_prdata = widen(num_low);
		end
		if (hit(paddr, `DRP_IDX_NUM_MID)) begin
			next_prdata = widen(num_mid);
		end
		if (hit(paddr, `DRP_IDX_NUM_HIGH)) begin
			next_prdata = widen(num_high);
		end
		if (hit(paddr, `DRP_IDX_MOD_LOW)) begin
			next_prdata = widen(mod_low);
		end
		if (hit(paddr, `DRP_IDX_MOD_MID)) begin
			next_prdata = widen(mod_mid);
		end
		if (hit(paddr, `DRP_IDX_MOD_HIGH)) begin
			next_prdata = widen(mod_high);
		end
		if (hit(paddr, `DRP_IDX_STATUS)) begin
			next_prdata = widen(status);
		end
	end

	// read data captured with pready so it is stable at the sampling edge
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (rd_now) begin
			prdata <= next_prdata;
		end else if (access) begin
			prdata <= 32'h0000_0000;
		end
	end

endmodule
`default_nettype wire

// File: rtl/drp_ratio.v
// effective feedback division ratio built from the stored divider fields
`timescale 1ns/1ns
`default_nettype none
`include "drp_defines.vh"

module drp_ratio #(
	parameter INT_W = 18,
	parameter FRAC_W = 24
) (
	input wire clock,
	input wire rst_n,
	input wire [INT_W-1:0] int_field,
	input wire [FRAC_W-1:0] num_field,
	input wire [FRAC_W-1:0] mod_field,
	output reg [INT_W:0] ratio_integer,
	output reg [FRAC_W-1:0] ratio_numerator,
	output reg [FRAC_W-1:0] ratio_modulus,
	output reg frac_bypass,
	output reg num_ge_mod
);

	// ----------------------------------------------------------------
	// ratio registers
	// ----------------------------------------------------------------
	wire mod_zero;
	assign mod_zero = (mod_field == {FRAC_W{1'b0}});

	// one cycle behind the fields, two behind the bank; a half-built field passes into the ratio as it is
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ratio_integer <= {{INT_W{1'b0}}, 1'b1};
			ratio_numerator <= {FRAC_W{1'b0}};
			ratio_modulus <= {FRAC_W{1'b0}};
			frac_bypass <= 1'b1;
			num_ge_mod <= 1'b0;
		end else begin
			ratio_integer <= {1'b0, int_field} + {{INT_W{1'b0}}, 1'b1};
			frac_bypass <= mod_zero;
			ratio_numerator <= mod_zero ? {FRAC_W{1'b0}} : num_field;
			ratio_modulus <= mod_field;
			// an improper fraction is legal but worth flagging
			num_ge_mod <= !mod_zero && (num_field >= mod_field);
		end
	end

endmodule
`default_nettype wire

// File: shared/drp_defines.vh
// register map, field positions, reset values and limits of the reference profile bank
`ifndef DRP_DEFINES_VH
`define DRP_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address on the bus is four times the index)
// ----------------------------------------------------------------
`define DRP_IDX_PRIO_EN 14'h0440
`define DRP_IDX_BW_LOW 14'h0441
`define DRP_IDX_BW_MID 14'h0442
`define DRP_IDX_FILT_BW_TOP 14'h0443
`define DRP_IDX_INT_LOW 14'h0444
`define DRP_IDX_INT_MID 14'h0445
`define DRP_IDX_INT_TOP 14'h0446
`define DRP_IDX_NUM_LOW 14'h0447
`define DRP_IDX_NUM_MID 14'h0448
`define DRP_IDX_NUM_HIGH 14'h0449
`define DRP_IDX_MOD_LOW 14'h044a
`define DRP_IDX_MOD_MID 14'h044b
`define DRP_IDX_MOD_HIGH 14'h044c
`define DRP_IDX_STATUS 14'h047f

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DRP_ENABLE_BIT 0
`define DRP_PRIO_MSB 2
`define DRP_PRIO_LSB 1
`define DRP_BW_TOP_BIT 0
`define DRP_FILTER_BIT 1
`define DRP_INT_TOP_MSB 1
`define DRP_ST_FRAC_BYPASS 0
`define DRP_ST_BW_ZERO 1
`define DRP_ST_FILTER_ADVICE 2
`define DRP_ST_NUM_GE_MOD 3
`define DRP_ST_ELIGIBLE 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DRP_RST_BYTE 8'h00
`define DRP_RST_PRIO 2'h0
`define DRP_RST_BW 17'h0_0000
`define DRP_RST_INT 18'h0_0000
`define DRP_RST_FRAC 24'h00_0000

// ----------------------------------------------------------------
// limits, bandwidth in steps of 0.1 Hz
// ----------------------------------------------------------------
`define DRP_BW_STEP_MHZ 100
`define DRP_HIGH_PM_ADVICE_HZ 2000
`define DRP_HIGH_PM_ADVICE 17'h0_4e20

`endif

// File: tb/drp_bank_props.sv
// concurrent checks on the ports of the reference profile bank
`timescale 1ns/1ns
`default_nettype none
module drp_bank_props (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ref_lock_enable,
	input wire logic [1:0] ref_priority,
	input wire logic [16:0] loop_bw_scale,
	input wire logic high_margin_filter,
	input wire logic [17:0] integer_feedback_divisor,
	input wire logic [23:0] fractional_numerator,
	input wire logic [23:0] fractional_modulus,
	input wire logic [18:0] ratio_integer,
	input wire logic [23:0] ratio_numerator,
	input wire logic frac_bypass
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// bus answer timing
	// ----------------------------------------
	a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("no answer one cycle after access");
	a_ready_one_pulse: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error flag without ready");

	// ----------------------------------------
	// fields follow writes, pipeline of two edges
	// ----------------------------------------
	a_prio_en_write: assert property (
		psel && penable && pready && pwrite && paddr == 16'h1100
		|-> ##2 {ref_priority, ref_lock_enable} == $past(pwdata[2:0], 2))
		else $error("priority or enable did not follow write");
	a_filter_write: assert property (
		psel && penable && pready && pwrite && paddr == 16'h110c
		|-> ##2 {high_margin_filter, loop_bw_scale[16]} == $past(pwdata[1:0], 2))
		else $error("filter or scale top bit did not follow write");

	// ----------------------------------------
	// derived ratio once the fields have settled
	// ----------------------------------------
	a_ratio_int_plus: assert property (
		$stable(integer_feedback_divisor)
		&& integer_feedback_divisor == $past(integer_feedback_divisor, 2)
		|-> ratio_integer == integer_feedback_divisor + 19'h0_0001)
		else $error("integer ratio is not stored value plus one");
	a_bypass_zero_mod: assert property (
		$stable(fractional_modulus) && fractional_modulus == $past(fractional_modulus, 2)
		|-> frac_bypass == (fractional_modulus == 24'h00_0000))
		else $error("bypass does not match zero modulus");
	a_ratio_num: assert property (
		$stable(fractional_numerator) && $stable(fractional_modulus)
		&& fractional_numerator == $past(fractional_numerator, 2)
		&& fractional_modulus == $past(fractional_modulus, 2)
		|-> ratio_numerator == ((fractional_modulus == 24'h00_0000) ? 24'h00_0000
		: fractional_numerator))
		else $error("ratio numerator wrong for modulus");
endmodule

bind drp_bank drp_bank_props u_drp_bank_props (.clock(clock), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .ref_lock_enable(ref_lock_enable), .ref_priority(ref_priority),
	.loop_bw_scale(loop_bw_scale), .high_margin_filter(high_margin_filter),
	.integer_feedback_divisor(integer_feedback_divisor), .fractional_numerator(fractional_numerator),
	.fractional_modulus(fractional_modulus), .ratio_integer(ratio_integer),
	.ratio_numerator(ratio_numerator), .frac_bypass(frac_bypass));
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the reference profile register bank
`timescale 1ns/1ns
`default_nettype none
`include "drp_defines.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
	$display("unexpected at %0t: got %h want %h", $time, a, e); end end
module tb;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic ref_lock_enable, high_margin_filter, frac_bypass, bw_zero_warning;
	logic [1:0] ref_priority;
	logic [16:0] loop_bw_scale;
	logic [17:0] integer_feedback_divisor;
	logic [18:0] ratio_integer;
	logic [23:0] fractional_numerator, fractional_modulus, ratio_numerator, ratio_modulus;
	int bad_count = 0;
	int n_compared = 0;

	drp_bank u_drp_bank (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ref_lock_enable(ref_lock_enable), .ref_priority(ref_priority),
		.loop_bw_scale(loop_bw_scale), .high_margin_filter(high_margin_filter),
		.integer_feedback_divisor(integer_feedback_divisor),
		.fractional_numerator(fractional_numerator), .fractional_modulus(fractional_modulus),
		.ratio_integer(ratio_integer), .ratio_numerator(ratio_numerator),
		.ratio_modulus(ratio_modulus), .frac_bypass(frac_bypass),
		.bw_zero_warning(bw_zero_warning));

	// 25 MHz clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// one apb transfer; psel stays up so a following call runs back-to-back
	task automatic apb(input logic w, input logic [13:0] idx, input logic [1:0] off,
		input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, off};
		pwdata <= {24'h00_0000, d};
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			$display("unexpected at %0t: no ready", $time);
		end
		rd = prdata;
		err = pslverr;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [13:0] idx, input logic [7:0] d);
		apb(1'b1, idx, 2'b00, d);
	endtask

	task automatic rdchk(input logic [13:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 2'b00, 8'h00);
		`CHK(rd, {24'h00_0000, e})
		`CHK(err, 1'b0)
	endtask

	// bus idle; outputs are stable long before the sampling edge
	task automatic settle();
		psel <= 1'b0;
		repeat (5) @(posedge clock);
	endtask

	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#60000;
		bad_count++;
		final_report();
	end

	// main sequence
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0000_0000;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 13; i++) rdchk(14'(14'h0440 + i), 8'h00);
		settle();
		`CHK(frac_bypass, 1'b1)
		`CHK(ratio_integer, 19'h0_0001)
		rdchk(`DRP_IDX_STATUS, 8'h03);
		$display("test reset done");
		// every priority code; reserved bits read back zero
		for (int p = 0; p < 4; p++) begin
			wr(`DRP_IDX_PRIO_EN, {5'h1f, p[1:0], p[0]});
			rdchk(`DRP_IDX_PRIO_EN, {5'h00, p[1:0], p[0]});
			settle();
			`CHK(ref_priority, p[1:0])
			`CHK(ref_lock_enable, p[0])
		end
		`CHK(bw_zero_warning, 1'b1)
		rdchk(`DRP_IDX_STATUS, 8'h13);
		$display("test priority done");
		wr(`DRP_IDX_BW_LOW, 8'h45);
		wr(`DRP_IDX_BW_MID, 8'h23);
		wr(`DRP_IDX_FILT_BW_TOP, 8'hff);
		rdchk(`DRP_IDX_FILT_BW_TOP, 8'h03);
		settle();
		`CHK(loop_bw_scale, 17'h1_2345)
		`CHK(high_margin_filter, 1'b1)
		`CHK(bw_zero_warning, 1'b0)
		wr(`DRP_IDX_FILT_BW_TOP, 8'h00);
		settle();
		`CHK(high_margin_filter, 1'b0)
		`CHK(loop_bw_scale, 17'h0_2345)
		wr(`DRP_IDX_FILT_BW_TOP, 8'h01);
		settle();
		`CHK(loop_bw_scale, 17'h1_2345)
		rdchk(`DRP_IDX_STATUS, 8'h15);
		$display("test bandwidth done");
		wr(`DRP_IDX_INT_LOW, 8'hff);
		wr(`DRP_IDX_INT_MID, 8'hff);
		wr(`DRP_IDX_INT_TOP, 8'hff);
		rdchk(`DRP_IDX_INT_TOP, 8'h03);
		settle();
		`CHK(integer_feedback_divisor, 18'h3_ffff)
		`CHK(ratio_integer, 19'h4_0000)
		wr(`DRP_IDX_INT_TOP, 8'h00);
		wr(`DRP_IDX_INT_LOW, 8'h00);
		settle();
		`CHK(ratio_integer, 19'h0_ff01)
		$display("test integer done");
		wr(`DRP_IDX_NUM_LOW, 8'h56);
		wr(`DRP_IDX_NUM_MID, 8'h34);
		wr(`DRP_IDX_NUM_HIGH, 8'h12);
		settle();
		`CHK(fractional_numerator, 24'h12_3456)
		`CHK(ratio_numerator, 24'h00_0000)
		`CHK(frac_bypass, 1'b1)
		wr(`DRP_IDX_MOD_LOW, 8'hef);
		wr(`DRP_IDX_MOD_MID, 8'hcd);
		wr(`DRP_IDX_MOD_HIGH, 8'hab);
		rdchk(`DRP_IDX_MOD_HIGH, 8'hab);
		settle();
		`CHK(fractional_modulus, 24'hab_cdef)
		`CHK(ratio_modulus, 24'hab_cdef)
		`CHK(ratio_numerator, 24'h12_3456)
		`CHK(frac_bypass, 1'b0)
		rdchk(`DRP_IDX_STATUS, 8'h14);
		// numerator above modulus is still taken as written
		wr(`DRP_IDX_MOD_HIGH, 8'h01);
		settle();
		`CHK(ratio_modulus, 24'h01_cdef)
		rdchk(`DRP_IDX_STATUS, 8'h1c);
		$display("test fraction done");
		// unmapped, misaligned and read-only places are refused
		apb(1'b0, 14'h044d, 2'b00, 8'h00);
		`CHK({err, rd}, {1'b1, 32'h0000_0000})
		apb(1'b1, `DRP_IDX_PRIO_EN, 2'b01, 8'h00);
		`CHK(err, 1'b1)
		apb(1'b1, `DRP_IDX_STATUS, 2'b00, 8'hff);
		`CHK(err, 1'b1)
		rdchk(`DRP_IDX_PRIO_EN, 8'h07);
		settle();
		$display("test refusal done");
		final_report();
	end
endmodule
`default_nettype wire
